// File: fieldbus_drive_control_registers.sv
// Holding-register bank between the fieldbus frame layer and the drive core.
// Assumes one register request per cycle at most, already decoded from the telegram.
`timescale 1ns/1ps

module fieldbus_drive_control_registers
    import fieldbus_regs_pkg::*;
(
    input  wire logic                        sys_clk_i,
    input  wire logic                        rstn_i,
    input  wire bus_req_t                    req_i,
    output bus_rsp_t                         rsp_o,
    input  wire logic [7:0]                  command_source_select_i,
    input  wire logic                        option_module_fitted_i,
    input  wire logic                        fieldbus_ramp_enable_i,
    input  wire drive_stat_t                 drive_stat_i,
    input  wire logic [MON_HI:MON_LO][15:0]  mon_words_i,
    output drive_cmd_t                       drive_cmd_o
);

    bank_state_t s_reg;
    bank_state_t s_next;

    ////////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        logic [15:0] reg_num;
        logic        ctrl_ok;
        logic        is_write;
        logic [15:0] status_word;
        s_next             = s_reg;
        s_next.rsp.valid   = 1'b0;
        reg_num            = req_i.wire_addr + WIRE_OFFSET;
        ctrl_ok            = (command_source_select_i == CMD_SRC_FIELDBUS)
                             && !option_module_fitted_i;
        is_write           = (req_i.func == FUNC_WRITE_ONE)
                             || (req_i.func == FUNC_WRITE_MULTI);
        // Fault code only meaningful while tripped
        status_word        = {(drive_stat_i.flags.tripped ? drive_stat_i.fault_code : BYTE_ZERO),
                              drive_stat_i.flags};

        // Ramp apply flag follows the enable every cycle, independent of command source
        s_next.drive.ramp_apply = fieldbus_ramp_enable_i;
        s_next.drive.ramp_time  = s_reg.ramp_word;

        if (req_i.valid) begin
            s_next.rsp.valid = 1'b1;
            s_next.rsp.exc   = EXC_NONE;
            s_next.rsp.rdata = req_i.wdata;
            if (req_i.func == FUNC_READ_MULTI) begin
                case (reg_num)
                    REG_CMD_WORD: begin
                        s_next.rsp.rdata = s_reg.cmd_word;
                    end
                    REG_SPEED: begin
                        s_next.rsp.rdata = s_reg.speed_word;
                    end
                    REG_SPARE: begin
                        s_next.rsp.rdata = s_reg.spare_word;
                    end
                    REG_RAMP: begin
                        s_next.rsp.rdata = s_reg.ramp_word;
                    end
                    REG_STATUS: begin
                        s_next.rsp.rdata = status_word;
                    end
                    REG_OUT_FREQ: begin
                        s_next.rsp.rdata = drive_stat_i.out_freq;
                    end
                    default: begin
                        if (reg_num >= REG_MON_LO && reg_num <= REG_MON_HI) begin
                            s_next.rsp.rdata = mon_words_i[reg_num[4:0]];
                        end else begin
                            s_next.rsp.rdata = WORD_RESET;
                            s_next.rsp.exc   = EXC_BAD_ADDR;
                        end
                    end
                endcase
            end else if (is_write) begin
                // Only registers 1-4 are writable, so multi-write is limited to them too
                case (reg_num)
                    REG_CMD_WORD: begin
                        s_next.cmd_word = req_i.wdata;
                        if (ctrl_ok) begin
                            s_next.drive.run         = req_i.wdata[CMD_RUN_BIT];
                            s_next.drive.fast_stop   = req_i.wdata[CMD_FAST_BIT];
                            // Held until the master writes it back to zero
                            s_next.drive.fault_reset = req_i.wdata[CMD_RESET_BIT];
                            s_next.drive.coast_stop  = req_i.wdata[CMD_COAST_BIT];
                        end
                    end
                    REG_SPEED: begin
                        s_next.speed_word = req_i.wdata;
                        if (ctrl_ok) begin
                            s_next.drive.speed = req_i.wdata;
                        end
                    end
                    REG_SPARE: begin
                        s_next.spare_word = req_i.wdata;
                    end
                    REG_RAMP: begin
                        if (req_i.wdata > RAMP_MAX) begin
                            s_next.rsp.exc = EXC_BAD_VALUE;
                        end else begin
                            s_next.ramp_word       = req_i.wdata;
                            s_next.drive.ramp_time = req_i.wdata;
                        end
                    end
                    default: begin
                        // Read-only or unmapped: nothing changes
                        s_next.rsp.exc = EXC_BAD_ADDR;
                    end
                endcase
            end else begin
                s_next.rsp.exc   = EXC_BAD_FUNC;
                s_next.rsp.rdata = WORD_RESET;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign rsp_o       = s_reg.rsp;
    assign drive_cmd_o = s_reg.drive;

endmodule : fieldbus_drive_control_registers

// File: fieldbus_drive_control_registers_bench.sv
// Self-checking bench for the drive control register bank.
// Assumes the master model drives requests; a watcher checks answers.
`timescale 1ns/1ps
module fieldbus_drive_control_registers_bench;
    import fieldbus_regs_pkg::*;
    logic                       sys_clk_i = 1'b0;
    logic                       rstn_i = 1'b0;
    bus_req_t                   req;
    bus_rsp_t                   rsp;
    logic [7:0]                 src = CMD_SRC_FIELDBUS;
    logic                       fitted = 1'b0;
    logic                       ramp_en = 1'b0;
    drive_stat_t                stat = '0;
    logic [MON_HI:MON_LO][15:0] mon = '0;
    drive_cmd_t                 cmd;
    logic [31:0]                lfsr = 32'hE64C;
    logic [24:0]                notes[$];
    logic [24:0]                note;
    int                         num_errors = 0;
    int                         checked = 0;
    fieldbus_master_model mst_u (.sys_clk_i(sys_clk_i), .req_o(req));
    fieldbus_drive_control_registers dut_u (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
        .req_i(req), .rsp_o(rsp), .command_source_select_i(src),
        .option_module_fitted_i(fitted), .fieldbus_ramp_enable_i(ramp_en),
        .drive_stat_i(stat), .mon_words_i(mon), .drive_cmd_o(cmd));
    ////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : rnd
    task automatic check(input string w, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", w, exp, seen);
        end
    endtask : check
    task automatic xact(input logic [7:0] f, input logic [15:0] r, input logic [15:0] d,
                        input logic [7:0] e, input logic c, input logic [15:0] x);
        notes.push_back({c, e, x});
        mst_u.send(f, r, d);
    endtask : xact
    task automatic end_of_test();
        check("pending", 16'(notes.size()), 16'h0000);
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_of_test
    initial begin
        forever #2 sys_clk_i = ~sys_clk_i;
    end
    always @(negedge sys_clk_i) begin
        if (rsp.valid === 1'b1) begin
            note = notes.pop_front();
            check("exc", {8'h00, rsp.exc}, {8'h00, note[23:16]});
            if (note[24]) check("rdata", rsp.rdata, note[15:0]);
        end
    end
    initial begin
        #4000;
        num_errors++;
        end_of_test();
    end
    initial begin
        repeat (16) @(posedge sys_clk_i);
        #1;
        rstn_i = 1'b1;
        for (int i = MON_LO; i <= MON_HI; i++) begin
            lfsr = rnd(lfsr);
            mon[i] = lfsr[15:0];
        end
        for (int b = 0; b < 5; b++) begin
            xact(FUNC_WRITE_ONE, REG_CMD_WORD, 16'h0010 >> (4 - b), EXC_NONE, 1'b1, 16'h0010 >> (4 - b));
            check("cmd", {12'h000, cmd.coast_stop, cmd.fault_reset, cmd.fast_stop, cmd.run},
                  (16'h0010 >> (4 - b)) & 16'h000F);
        end
        xact(FUNC_WRITE_ONE, REG_SPEED, 16'h01F4, EXC_NONE, 1'b1, 16'h01F4);
        for (int g = 0; g < 2; g++) begin
            fitted = (g == 0);
            src = (g == 0) ? CMD_SRC_FIELDBUS : 8'h03;
            xact(FUNC_WRITE_ONE, REG_CMD_WORD, 16'h0009, EXC_NONE, 1'b1, 16'h0009);
            xact(FUNC_READ_MULTI, REG_CMD_WORD, 16'h0000, EXC_NONE, 1'b1, 16'h0009);
            check("gated", {15'h0000, cmd.run | cmd.coast_stop}, 16'h0000);
        end
        check("speed", cmd.speed, 16'h01F4);
        src = 8'h00;
        ramp_en = 1'b1;
        lfsr = rnd(lfsr);
        stat = {lfsr[7:2], 1'b1, lfsr[0], lfsr[15:8], lfsr[31:16]};
        xact(FUNC_READ_MULTI, REG_STATUS, 16'h0000, EXC_NONE, 1'b1, {lfsr[15:8], stat.flags});
        stat.flags.tripped = 1'b0;
        xact(FUNC_READ_MULTI, REG_STATUS, 16'h0000, EXC_NONE, 1'b1, {8'h00, stat.flags});
        xact(FUNC_READ_MULTI, REG_OUT_FREQ, 16'h0000, EXC_NONE, 1'b1, lfsr[31:16]);
        xact(FUNC_WRITE_ONE, REG_OUT_FREQ, 16'h1234, EXC_BAD_ADDR, 1'b0, 16'h0000);
        xact(FUNC_READ_MULTI, REG_MON_HI, 16'h0000, EXC_NONE, 1'b1, mon[24]);
        xact(FUNC_READ_MULTI, 16'h0019, 16'h0000, EXC_BAD_ADDR, 1'b1, 16'h0000);
        xact(8'h05, REG_SPEED, 16'h0000, EXC_BAD_FUNC, 1'b0, 16'h0000);
        xact(FUNC_WRITE_MULTI, 16'h0005, 16'h0001, EXC_BAD_ADDR, 1'b0, 16'h0000);
        xact(FUNC_WRITE_MULTI, REG_SPARE, 16'h1234, EXC_NONE, 1'b1, 16'h1234);
        xact(FUNC_WRITE_ONE, REG_RAMP, RAMP_MAX, EXC_NONE, 1'b1, RAMP_MAX);
        xact(FUNC_WRITE_ONE, REG_RAMP, 16'hEA61, EXC_BAD_VALUE, 1'b0, 16'h0000);
        mst_u.idle();
        repeat (3) @(posedge sys_clk_i);
        #1;
        check("ramp", cmd.ramp_time, RAMP_MAX);
        check("apply", {15'h0000, cmd.ramp_apply}, 16'h0001);
        end_of_test();
    end
endmodule : fieldbus_drive_control_registers_bench

// File: fieldbus_master_model.sv
// Fieldbus master model: one register request per send call.
// Assumes calls are made just after a rising clock edge.
`timescale 1ns/1ps
module fieldbus_master_model
    import fieldbus_regs_pkg::*;
(
    input  wire logic sys_clk_i,
    output bus_req_t  req_o
);
    initial req_o = '0;
    ////////////////////////////////////////////////////////////////
    task automatic send(input logic [7:0] f, input logic [15:0] num, input logic [15:0] d);
        req_o = {1'b1, f, num - WIRE_OFFSET, d};
        @(posedge sys_clk_i);
        #1;
    endtask : send
    // Released fields flip so stale values never pass
    task automatic idle();
        req_o = {1'b0, ~req_o[39:0]};
    endtask : idle
endmodule : fieldbus_master_model

// File: fieldbus_regs_monitor.sv
// Assertion checker for the drive control register bank.
// Assumes binding to the bank top; sees only its ports.
`timescale 1ns/1ps
module fieldbus_regs_monitor
    import fieldbus_regs_pkg::*;
(
    input  wire logic                       sys_clk_i,
    input  wire logic                       rstn_i,
    input  wire bus_req_t                   req_i,
    input  wire bus_rsp_t                   rsp_o,
    input  wire logic [7:0]                 command_source_select_i,
    input  wire logic                       option_module_fitted_i,
    input  wire logic                       fieldbus_ramp_enable_i,
    input  wire drive_stat_t                drive_stat_i,
    input  wire logic [MON_HI:MON_LO][15:0] mon_words_i,
    input  wire drive_cmd_t                 drive_cmd_o
);
    logic       wr;
    logic       rd;
    logic       src_ok;
    logic [3:0] bits;
    assign wr     = req_i.valid && req_i.func == FUNC_WRITE_ONE;
    assign rd     = req_i.valid && req_i.func == FUNC_READ_MULTI;
    assign src_ok = command_source_select_i == CMD_SRC_FIELDBUS && !option_module_fitted_i;
    assign bits   = {drive_cmd_o.coast_stop, drive_cmd_o.fault_reset,
                     drive_cmd_o.fast_stop, drive_cmd_o.run};
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);
    ////////////////////////////////////////////////////////////////
    AST_ANSWER: assert property (req_i.valid |=> rsp_o.valid)
        else $error("request not answered");
    AST_CMD_BITS: assert property (wr && src_ok && req_i.wire_addr == 16'h0000
        |=> bits == $past(req_i.wdata[3:0])) else $error("command bits wrong");
    AST_GATED: assert property (wr && !src_ok && req_i.wire_addr == 16'h0000
        |=> $stable(bits)) else $error("gated write reached drive");
    AST_RAMP_APPLY: assert property ($past(rstn_i)
        |-> drive_cmd_o.ramp_apply == $past(fieldbus_ramp_enable_i)) else $error("ramp apply");
    AST_RAMP_LIMIT: assert property (wr && req_i.wire_addr == 16'h0003 && req_i.wdata > RAMP_MAX
        |=> rsp_o.exc == EXC_BAD_VALUE) else $error("ramp limit");
    AST_STATUS: assert property (rd && req_i.wire_addr == 16'h0005
        |=> rsp_o.rdata == {($past(drive_stat_i.flags.tripped) ? $past(drive_stat_i.fault_code)
        : BYTE_ZERO), $past(drive_stat_i.flags)}) else $error("status word");
    AST_FREQ: assert property (rd && req_i.wire_addr == 16'h0006
        |=> rsp_o.rdata == $past(drive_stat_i.out_freq)) else $error("frequency");
    AST_RO: assert property (wr && req_i.wire_addr > 16'h0003
        |=> rsp_o.exc == EXC_BAD_ADDR) else $error("read-only write taken");
    AST_MON: assert property (rd && req_i.wire_addr == 16'h0017
        |=> rsp_o.rdata == $past(mon_words_i[24])) else $error("monitor word");
endmodule : fieldbus_regs_monitor
bind fieldbus_drive_control_registers fieldbus_regs_monitor mon_u (.sys_clk_i, .rstn_i, .req_i,
    .rsp_o, .command_source_select_i, .option_module_fitted_i, .fieldbus_ramp_enable_i,
    .drive_stat_i, .mon_words_i, .drive_cmd_o);

// File: fieldbus_regs_pkg.sv
// Constants and carrier types for the fieldbus drive control register bank.
// Assumes a frame layer outside that splits each telegram into one request per register.
//
// Summary of operation
// - Control writes act only with fieldbus source, no module; ramp word writes reach the drive with any source
// - Ramp word applied only when fieldbus ramp enabled
// - Monitoring registers 8 to 24 always readable
// - Command bit 0 runs or stops drive
// - Command bit 1 stops on fast ramp
// - Command bit 2 clears all active faults
// - Command bit 3 coasts the motor
// - Ramp word 0 to 60000 hundredths second
// - Status bits: running, tripped, hand mode
// - Status bits: inhibit, service, standby, ready, load
// - Upper status byte holds trip fault code
// - Status word: fault code high, flags low
// - Register 7 reads output frequency, read-only
// - Functions 03, 06; 16 only registers 1-4
package fieldbus_regs_pkg;

    // Register numbers as documented (one based)
    localparam logic [15:0] REG_CMD_WORD   = 16'h0001;
    localparam logic [15:0] REG_SPEED      = 16'h0002;
    localparam logic [15:0] REG_SPARE      = 16'h0003;
    localparam logic [15:0] REG_RAMP       = 16'h0004;
    localparam logic [15:0] REG_STATUS     = 16'h0006;
    localparam logic [15:0] REG_OUT_FREQ   = 16'h0007;
    localparam int          MON_LO         = 8;
    localparam int          MON_HI         = 24;
    localparam logic [15:0] REG_MON_LO     = 16'h0008;
    localparam logic [15:0] REG_MON_HI     = 16'h0018;
    localparam logic [15:0] WIRE_OFFSET    = 16'h0001;

    // Function codes and exception answers
    localparam logic [7:0]  FUNC_READ_MULTI  = 8'h03;
    localparam logic [7:0]  FUNC_WRITE_ONE   = 8'h06;
    localparam logic [7:0]  FUNC_WRITE_MULTI = 8'h10;
    localparam logic [7:0]  EXC_NONE         = 8'h00;
    localparam logic [7:0]  EXC_BAD_FUNC     = 8'h01;
    localparam logic [7:0]  EXC_BAD_ADDR     = 8'h02;
    localparam logic [7:0]  EXC_BAD_VALUE    = 8'h03;

    // Command word bit positions
    localparam int CMD_RUN_BIT   = 0;
    localparam int CMD_FAST_BIT  = 1;
    localparam int CMD_RESET_BIT = 2;
    localparam int CMD_COAST_BIT = 3;

    localparam logic [7:0]  CMD_SRC_FIELDBUS = 8'h04;
    localparam logic [15:0] RAMP_MAX         = 16'hEA60;
    localparam logic [15:0] WORD_RESET       = 16'h0000;
    localparam logic [7:0]  BYTE_ZERO        = 8'h00;

    typedef struct packed {
        logic        valid;
        logic [7:0]  func;
        logic [15:0] wire_addr;
        logic [15:0] wdata;
    } bus_req_t;

    typedef struct packed {
        logic        valid;
        logic [7:0]  exc;
        logic [15:0] rdata;
    } bus_rsp_t;

    // Low byte of the status word, bit 7 first
    typedef struct packed {
        logic load_alarm;
        logic ready;
        logic standby;
        logic service_due;
        logic inhibit;
        logic hand;
        logic tripped;
        logic running;
    } status_flags_t;

    typedef struct packed {
        status_flags_t flags;
        logic [7:0]    fault_code;
        logic [15:0]   out_freq;
    } drive_stat_t;

    typedef struct packed {
        logic        run;
        logic        fast_stop;
        logic        fault_reset;
        logic        coast_stop;
        logic [15:0] speed;
        logic        ramp_apply;
        logic [15:0] ramp_time;
    } drive_cmd_t;

    typedef struct packed {
        logic [15:0] cmd_word;
        logic [15:0] speed_word;
        logic [15:0] spare_word;
        logic [15:0] ramp_word;
        drive_cmd_t  drive;
        bus_rsp_t    rsp;
    } bank_state_t;

endpackage : fieldbus_regs_pkg
